// ==== rtl/uadc_pin_sync.sv ====
// Two-stage synchroniser for the programmable I/O inputs.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module uadc_pin_sync
    import uadc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [UADC_PIO_N-1:0] pin_async,
    output logic [UADC_PIO_N-1:0] pin_sync
);

    genvar gi;
    generate
        for (gi = 0; gi < UADC_PIO_N; gi++) begin : g_sync
            logic meta_q;
            logic meta_d;
            logic sync_q;
            logic sync_d;
            always_comb begin
                meta_d = pin_async[gi];
                sync_d = meta_q;
            end
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    sync_q <= sync_d;
                end
            end
            assign pin_sync[gi] = sync_q;
        end
    endgenerate

endmodule

// ==== rtl/uadc_pkg.sv ====
// Package for the USB attach and detach control block.
// Assumes one 25 MHz system clock and a plain register port.
package uadc_pkg;

    // Clock and link rates
    localparam int unsigned UADC_CLK_HZ = 25_000_000;
    localparam int unsigned UADC_FS_BITRATE = 12_000_000;

    // Pin set
    localparam int unsigned UADC_PIO_N = 16;
    localparam int unsigned UADC_PIO_W = 4;

    // Register offsets
    localparam logic [7:0] UADC_OFS_CTRL = 8'h00;
    localparam logic [7:0] UADC_OFS_PULLUP = 8'h04;
    localparam logic [7:0] UADC_OFS_VBUS_SEL = 8'h08;
    localparam logic [7:0] UADC_OFS_DETACH_SEL = 8'h0c;
    localparam logic [7:0] UADC_OFS_WAKE_SEL = 8'h10;
    localparam logic [7:0] UADC_OFS_STATUS = 8'h14;
    localparam logic [7:0] UADC_OFS_POWER = 8'h18;

    // Control field positions
    localparam int unsigned UADC_CTRL_READY_BIT = 0;
    localparam int unsigned UADC_CTRL_SELF_BIT = 1;
    localparam int unsigned UADC_CTRL_AUDIO_BIT = 2;
    localparam int unsigned UADC_CTRL_WAKE_BIT = 3;
    localparam int unsigned UADC_CTRL_W = 4;

    // Reset values
    localparam logic [3:0] UADC_CTRL_RST = 4'h0;
    localparam logic [4:0] UADC_PULL_INTERNAL = 5'h10;
    localparam logic [4:0] UADC_PULLUP_RST = 5'h10;
    localparam logic [3:0] UADC_VBUS_SEL_RST = 4'h2;
    localparam logic [3:0] UADC_DETACH_SEL_RST = 4'h3;
    localparam logic [3:0] UADC_WAKE_SEL_RST = 4'h4;

    // Power budget in 2 mA units, 100 mA when bus powered
    localparam logic [7:0] UADC_MAX_POWER_BUS = 8'h32;
    localparam logic [7:0] UADC_MAX_POWER_SELF = 8'h00;

    typedef enum logic [1:0] {
        UADC_S_OFF = 2'b00,
        UADC_S_ATTACH = 2'b01,
        UADC_S_SUSPEND = 2'b11,
        UADC_S_DETACH = 2'b10
    } uadc_state_t;

    typedef struct packed {
        logic wake_req;
        logic audio_ep;
        logic self_powered;
        logic enum_ready;
    } uadc_ctrl_t;

    typedef struct packed {
        logic cfg_err;
        logic radio_en;
        logic wake_out;
        logic vbus_present;
        logic detached;
        logic pullup_on;
        uadc_state_t state;
    } uadc_status_t;

endpackage

// ==== rtl/uadc_top.sv ====
// Attach, detach, wake and suspend control for a full-speed USB port.
// Assumes the USB core on clk_sys and asynchronous programmable I/O pins.
// Operation
// - The port is a full-speed 12 Mbit/s interface with its own transceiver.
// - The port acts only as a slave and drives the bus only in answer to the host.
// - Software picks either the wireless endpoint set or the audio endpoint set.
// - When ready to enumerate the block pulls the D+ line weakly high.
// - The pull-up source setting picks internal (value 16, default) or a pin.
// - When self powered the pull-up stays off while VBUS is absent.
// - A pin number setting picks the VBUS sense pin and must match the pull-up pin.
// - When bus powered the configuration asks for a 100 mA budget.
// - The host may suspend the port, and then a bus-powered port keeps its radio off.
// - Detach input and wake output each sit on a pin chosen by its own setting.
// - A high detach input puts both data lines in high impedance and drops the pull-up.
// - A low detach input restores the pull-up and the port awaits enumeration.
// - The wake output goes high to wake the host, only while detached.
// - The in-band remote wake is never sent while detached.
`timescale 1ns/1ps
module uadc_top
    import uadc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic [UADC_PIO_N-1:0] pio_in,
    output logic [UADC_PIO_N-1:0] pio_out,
    output logic [UADC_PIO_N-1:0] pio_oe,
    input wire logic core_suspend,
    input wire logic core_tx_oe,
    input wire logic core_remote_wake,
    output logic usb_tx_oe,
    output logic dplus_int_pullup,
    output logic inband_wake_go,
    output logic radio_en,
    output logic audio_ep_sel,
    output logic [7:0] max_power
);

    localparam int unsigned FS_DIV_RATIO = UADC_CLK_HZ / UADC_FS_BITRATE;

    uadc_ctrl_t ctrl_q, ctrl_d;
    logic [4:0] pullup_src_q, pullup_src_d;
    logic [3:0] vbus_sel_q, vbus_sel_d;
    logic [3:0] detach_sel_q, detach_sel_d;
    logic [3:0] wake_sel_q, wake_sel_d;
    logic [31:0] rdata_q, rdata_d;

    uadc_state_t state_q, state_d;
    logic pull_ext_q, pull_ext_d;
    logic pull_int_q, pull_int_d;
    logic wake_q, wake_d;
    logic radio_q, radio_d;
    logic [UADC_PIO_N-1:0] pio_out_q, pio_out_d;
    logic [UADC_PIO_N-1:0] pio_oe_q, pio_oe_d;

    logic [UADC_PIO_N-1:0] pio_s;
    logic detach_s;
    logic vbus_s;
    logic vbus_ok;
    logic cfg_err;
    logic pull_on_d;
    uadc_status_t status;

    // Pins are asynchronous; two flops before use
    uadc_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_async(pio_in),
        .pin_sync(pio_s)
    );

    // Selected input pins
    always_comb begin
        detach_s = pio_s[detach_sel_q];
        vbus_s = pio_s[vbus_sel_q];
        vbus_ok = !ctrl_q.self_powered || vbus_s;
        cfg_err = ctrl_q.self_powered && (pullup_src_q != {1'b0, vbus_sel_q});
    end

    // Connection state
    always_comb begin
        state_d = state_q;
        case (state_q)
            UADC_S_OFF: begin
                if (ctrl_q.enum_ready && vbus_ok) begin
                    state_d = UADC_S_ATTACH;
                end
            end
            UADC_S_ATTACH: begin
                if (!ctrl_q.enum_ready || !vbus_ok) begin
                    state_d = UADC_S_OFF;
                end else if (core_suspend) begin
                    state_d = UADC_S_SUSPEND;
                end
            end
            UADC_S_SUSPEND: begin
                if (!ctrl_q.enum_ready || !vbus_ok) begin
                    state_d = UADC_S_OFF;
                end else if (!core_suspend) begin
                    state_d = UADC_S_ATTACH;
                end
            end
            UADC_S_DETACH: begin
                if (!detach_s) begin
                    state_d = UADC_S_OFF;
                end
            end
            default: begin
                state_d = UADC_S_OFF;
            end
        endcase
        if (detach_s) begin
            state_d = UADC_S_DETACH;
        end
    end

    // Registered pin and line drives
    always_comb begin
        pull_on_d = (state_d == UADC_S_ATTACH) || (state_d == UADC_S_SUSPEND);
        pull_int_d = pull_on_d && (pullup_src_q == UADC_PULL_INTERNAL);
        pull_ext_d = pull_on_d && !pullup_src_q[4];
        wake_d = (state_d == UADC_S_DETACH) && ctrl_q.wake_req;
        // Power mode written this cycle applies with the new state
        radio_d = !((state_d == UADC_S_SUSPEND) && !ctrl_d.self_powered);
        pio_out_d = '0;
        pio_oe_d = '0;
        if (pull_ext_d) begin
            pio_out_d[pullup_src_q[3:0]] = 1'b1;
            pio_oe_d[pullup_src_q[3:0]] = 1'b1;
        end
        pio_out_d[wake_sel_q] = wake_d;
        pio_oe_d[wake_sel_q] = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= UADC_S_OFF;
            pull_ext_q <= 1'b0;
            pull_int_q <= 1'b0;
            wake_q <= 1'b0;
            radio_q <= 1'b1;
            pio_out_q <= '0;
            pio_oe_q <= '0;
        end else begin
            state_q <= state_d;
            pull_ext_q <= pull_ext_d;
            pull_int_q <= pull_int_d;
            wake_q <= wake_d;
            radio_q <= radio_d;
            pio_out_q <= pio_out_d;
            pio_oe_q <= pio_oe_d;
        end
    end

    // Status view
    always_comb begin
        status.cfg_err = cfg_err;
        status.radio_en = radio_q;
        status.wake_out = wake_q;
        status.vbus_present = vbus_s;
        status.detached = (state_q == UADC_S_DETACH);
        status.pullup_on = pull_int_q || pull_ext_q;
        status.state = state_q;
    end

    // Register writes and reads
    always_comb begin
        ctrl_d = ctrl_q;
        pullup_src_d = pullup_src_q;
        vbus_sel_d = vbus_sel_q;
        detach_sel_d = detach_sel_q;
        wake_sel_d = wake_sel_q;
        rdata_d = '0;
        if (reg_we) begin
            case (reg_addr)
                UADC_OFS_CTRL: ctrl_d = uadc_ctrl_t'(reg_wdata[UADC_CTRL_W-1:0]);
                UADC_OFS_PULLUP: pullup_src_d = reg_wdata[4:0];
                UADC_OFS_VBUS_SEL: vbus_sel_d = reg_wdata[3:0];
                UADC_OFS_DETACH_SEL: detach_sel_d = reg_wdata[3:0];
                UADC_OFS_WAKE_SEL: wake_sel_d = reg_wdata[3:0];
                default: begin
                end
            endcase
        end
        if (reg_re) begin
            case (reg_addr)
                UADC_OFS_CTRL: rdata_d = {28'h0000000, ctrl_q};
                UADC_OFS_PULLUP: rdata_d = {27'h0000000, pullup_src_q};
                UADC_OFS_VBUS_SEL: rdata_d = {28'h0000000, vbus_sel_q};
                UADC_OFS_DETACH_SEL: rdata_d = {28'h0000000, detach_sel_q};
                UADC_OFS_WAKE_SEL: rdata_d = {28'h0000000, wake_sel_q};
                UADC_OFS_STATUS: rdata_d = {24'h000000, status};
                UADC_OFS_POWER: rdata_d = {24'h000000, max_power};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= uadc_ctrl_t'(UADC_CTRL_RST);
            pullup_src_q <= UADC_PULLUP_RST;
            vbus_sel_q <= UADC_VBUS_SEL_RST;
            detach_sel_q <= UADC_DETACH_SEL_RST;
            wake_sel_q <= UADC_WAKE_SEL_RST;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            pullup_src_q <= pullup_src_d;
            vbus_sel_q <= vbus_sel_d;
            detach_sel_q <= detach_sel_d;
            wake_sel_q <= wake_sel_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign pio_out = pio_out_q;
    assign pio_oe = pio_oe_q;
    assign dplus_int_pullup = pull_int_q;
    assign radio_en = radio_q;
    assign audio_ep_sel = ctrl_q.audio_ep;
    // Drive only while attached, in answer to the host
    assign usb_tx_oe = core_tx_oe && ((state_q == UADC_S_ATTACH)
        || (state_q == UADC_S_SUSPEND));
    assign inband_wake_go = core_remote_wake && (state_q == UADC_S_SUSPEND);
    assign max_power = ctrl_q.self_powered ? UADC_MAX_POWER_SELF : UADC_MAX_POWER_BUS;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic pull_any;
    assign pull_any = pull_int_q || pull_ext_q;

    a_detach_drops_pull: assert property (detach_s |=> !pull_any && !usb_tx_oe)
        else $error("pull-up or drive left on while detached");
    a_vbus_blocks_pull: assert property (ctrl_q.self_powered && !vbus_s |=> !pull_any)
        else $error("pull-up on without VBUS in self powered mode");
    a_not_ready_off: assert property (!ctrl_q.enum_ready |=> !pull_any)
        else $error("pull-up on before ready to enumerate");
    a_ready_attaches: assert property ((state_q == UADC_S_OFF) && ctrl_q.enum_ready
        && vbus_ok && !detach_s |=> pull_any)
        else $error("pull-up not applied when ready");
    a_reattach_seq: assert property ((state_q == UADC_S_DETACH) && !detach_s
        ##1 (ctrl_q.enum_ready && vbus_ok && !detach_s) |=> pull_any)
        else $error("no reattach after detach released");
    a_radio_quiet: assert property ((state_q == UADC_S_SUSPEND) && !ctrl_q.self_powered
        |-> !radio_en)
        else $error("radio on in bus powered suspend");
    a_wake_only_det: assert property (pio_oe[wake_sel_q] && pio_out[wake_sel_q]
        && !$changed(wake_sel_q) && wake_q |-> (state_q == UADC_S_DETACH))
        else $error("wake output high while attached");
    a_inband_blocked: assert property ((state_q == UADC_S_DETACH) |-> !inband_wake_go)
        else $error("in-band wake sent while detached");
    a_power_budget: assert property (!ctrl_q.self_powered |-> max_power == 8'h32)
        else $error("wrong bus powered budget");
    a_int_source: assert property (pull_int_q |-> $past(pullup_src_q) == 5'h10)
        else $error("internal pull-up with external source set");
    a_read_lat: assert property (reg_re && reg_addr == UADC_OFS_PULLUP
        |=> reg_rdata == {27'h0000000, $past(pullup_src_q)})
        else $error("read data wrong one cycle after strobe");

    // Line drive and wake checks
    a_detach_no_tx: assert property ((state_q == UADC_S_DETACH) |-> !usb_tx_oe)
        else $error("data lines driven while detached");
    a_tx_only_host: assert property (usb_tx_oe |-> core_tx_oe)
        else $error("data lines driven without a host request");
    a_inband_suspend: assert property (inband_wake_go |-> (state_q == UADC_S_SUSPEND))
        else $error("in-band wake outside suspend");
    a_detach_wake: assert property (detach_s && ctrl_q.wake_req |=> wake_q)
        else $error("wake output not raised while detached");

    // Suspend and power checks
    a_suspend_enter: assert property ((state_q == UADC_S_ATTACH) && ctrl_q.enum_ready
        && vbus_ok && !detach_s && core_suspend |=> (state_q == UADC_S_SUSPEND))
        else $error("host suspend not accepted");
    a_radio_awake: assert property ((state_q != UADC_S_SUSPEND) |-> radio_en)
        else $error("radio off outside suspend");
    a_power_self: assert property (ctrl_q.self_powered |-> max_power == 8'h00)
        else $error("self powered budget not zero");

    // Pull-up source checks
    a_ext_pin_drive: assert property (pull_ext_q
        && ($past(wake_sel_q) != $past(pullup_src_q[3:0]))
        |-> pio_oe[$past(pullup_src_q[3:0])] && pio_out[$past(pullup_src_q[3:0])])
        else $error("external pull-up pin not driven high");
    a_ext_src_pin: assert property (pull_ext_q |-> !$past(pullup_src_q[4]))
        else $error("external pull-up with no pin selected");

    c_attach: cover property ((state_q == UADC_S_OFF) ##1 (state_q == UADC_S_ATTACH));
    c_suspend: cover property ((state_q == UADC_S_ATTACH) ##1 (state_q == UADC_S_SUSPEND));
    c_detach_wake: cover property ((state_q == UADC_S_DETACH) && wake_q);
    c_self_suspend: cover property ((state_q == UADC_S_SUSPEND) && ctrl_q.self_powered && radio_en);
    c_reattach: cover property ((state_q == UADC_S_DETACH) ##1 (state_q == UADC_S_OFF)
        ##1 (state_q == UADC_S_ATTACH));

endmodule

// ==== tb/uadc_host_model.sv ====
// Host controller model facing the USB attach and detach control block.
// Assumes one clk_sys and that the bench issues VBUS and suspend requests.
`timescale 1ns/1ps
module uadc_host_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic dplus_line,
    input wire logic vbus_req,
    input wire logic suspend_req,
    output logic host_vbus,
    output logic host_suspend,
    output int attach_cnt
);
    logic seen_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
            host_vbus <= 1'b0;
            host_suspend <= 1'b0;
            attach_cnt <= 0;
        end else begin
            seen_q <= dplus_line;
            host_vbus <= vbus_req;
            // Suspends only an attached device
            host_suspend <= suspend_req & dplus_line;
            // New pull-up starts an enumeration
            if (dplus_line && !seen_q) begin
                attach_cnt <= attach_cnt + 1;
            end
        end
    end
endmodule

// ==== tb/uadc_top_tb_top.sv ====
// Self-checking bench for the USB attach and detach control block.
// Assumes the host model on the pins and a one-cycle register port.
`timescale 1ns/1ps
`define CHK(G, E) chk(32'(G), 32'(E))
module uadc_top_tb_top;
    import uadc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] pio_in;
    logic [15:0] pio_out;
    logic [15:0] pio_oe;
    logic core_tx_oe = 1'b0;
    logic core_remote_wake = 1'b0;
    logic usb_tx_oe, dplus_int_pullup, inband_wake_go, radio_en, audio_ep_sel;
    logic [7:0] max_power;
    logic host_vbus, host_suspend, dp_line;
    logic vbus_req = 1'b0;
    logic suspend_req = 1'b0;
    int attach_cnt, mismatches = 0, cmp_count = 0;
    logic m_ready = 1'b0, m_self = 1'b0, m_audio = 1'b0, m_wake = 1'b0, m_det = 1'b0;
    logic [4:0] m_pull = 5'h10;
    logic [3:0] m_vsel = 4'h2;
    logic [3:0] m_dsel = UADC_DETACH_SEL_RST;
    logic [3:0] m_wsel = UADC_WAKE_SEL_RST;
    logic [15:0] bg = 16'h0;

    always #20 clk_sys = ~clk_sys;

    always_comb begin
        pio_in = bg;
        pio_in[m_vsel] = host_vbus;
        pio_in[m_dsel] = m_det;
    end
    assign dp_line = dplus_int_pullup | (m_pull < 5'h10 && pio_oe[m_pull[3:0]]
        && pio_out[m_pull[3:0]]);

    uadc_top uadc_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .pio_in(pio_in), .pio_out(pio_out), .pio_oe(pio_oe), .core_suspend(host_suspend),
        .core_tx_oe(core_tx_oe), .core_remote_wake(core_remote_wake),
        .usb_tx_oe(usb_tx_oe), .dplus_int_pullup(dplus_int_pullup),
        .inband_wake_go(inband_wake_go), .radio_en(radio_en),
        .audio_ep_sel(audio_ep_sel), .max_power(max_power));

    uadc_host_model uadc_host_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .dplus_line(dp_line), .vbus_req(vbus_req), .suspend_req(suspend_req),
        .host_vbus(host_vbus), .host_suspend(host_suspend), .attach_cnt(attach_cnt));

    task automatic chk(logic [31:0] g, logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic reg_wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask

    task automatic reg_rd(logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic cfg(logic [3:0] c, logic [4:0] p, logic [3:0] v);
        reg_wr(UADC_OFS_CTRL, {28'h0, c});
        reg_wr(UADC_OFS_PULLUP, {27'h0, p});
        reg_wr(UADC_OFS_VBUS_SEL, {28'h0, v});
        {m_wake, m_audio, m_self, m_ready} <= c;
        m_pull <= p;
        m_vsel <= v;
    endtask

    // Model of the expected status byte
    function automatic logic [7:0] exp_status();
        logic [1:0] st;
        st = m_det ? 2'b10 : ((m_ready && (!m_self || host_vbus)) ?
            (host_suspend ? 2'b11 : 2'b01) : 2'b00);
        return {m_self && ({1'b0, m_vsel} != m_pull), !(st == 2'b11 && !m_self),
            m_det && m_wake, host_vbus, m_det, st[0], st};
    endfunction

    task automatic check_all(string name);
        logic [31:0] d;
        logic [7:0] s;
        logic [15:0] oe;
        logic [15:0] po;
        @(posedge clk_sys);
        core_tx_oe <= 1'($urandom);
        core_remote_wake <= 1'($urandom);
        bg <= 16'($urandom);
        repeat (6) @(posedge clk_sys);
        reg_rd(UADC_OFS_STATUS, d);
        s = exp_status();
        oe = 16'h0000;
        po = 16'h0000;
        oe[m_wsel] = 1'b1;
        po[m_wsel] = s[5];
        if (s[2] && m_pull < 5'h10) begin
            oe[m_pull[3:0]] = 1'b1;
            po[m_pull[3:0]] = 1'b1;
        end
        `CHK(d, {24'h0, s});
        reg_rd(UADC_OFS_POWER, d);
        `CHK(d, {24'h0, m_self ? UADC_MAX_POWER_SELF : UADC_MAX_POWER_BUS});
        `CHK(max_power, m_self ? UADC_MAX_POWER_SELF : UADC_MAX_POWER_BUS);
        `CHK(dplus_int_pullup, s[2] && m_pull == 5'h10);
        `CHK(pio_oe, oe);
        `CHK(pio_out & oe, po);
        `CHK(radio_en, s[6]);
        `CHK(usb_tx_oe, core_tx_oe & s[0]);
        `CHK(inband_wake_go, core_remote_wake && s[1:0] == 2'b11);
        `CHK(audio_ep_sel, m_audio);
        $display("test %s done", name);
    endtask

    initial begin
        logic [7:0] ra [6];
        logic [31:0] rv [6];
        logic [31:0] d;
        logic [4:0] p;
        int cnt;
        ra = '{UADC_OFS_CTRL, UADC_OFS_PULLUP, UADC_OFS_VBUS_SEL, UADC_OFS_DETACH_SEL,
            UADC_OFS_WAKE_SEL, 8'h1c};
        rv = '{32'h0, 32'h10, 32'h2, 32'h3, 32'h4, 32'h0};
        void'($urandom(82));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_wr(8'h1c, 32'hffff_ffff);
        reg_wr(UADC_OFS_STATUS, 32'hff);
        foreach (ra[i]) begin
            reg_rd(ra[i], d);
            `CHK(d, rv[i]);
        end
        check_all("reset");
        cfg(4'h5, 5'h10, 4'h2);
        check_all("bus_attach");
        `CHK(attach_cnt, 1);
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk_sys);
            suspend_req <= 1'(i);
            check_all("suspend");
        end
        cfg(4'h9, 5'h10, 4'h2);
        @(posedge clk_sys);
        suspend_req <= 1'b1;
        check_all("suspend_before_detach");
        @(posedge clk_sys);
        m_det <= 1'b1;
        check_all("detach");
        cnt = attach_cnt;
        @(posedge clk_sys);
        m_det <= 1'b0;
        suspend_req <= 1'b0;
        check_all("reattach");
        `CHK(attach_cnt, cnt + 1);
        p = 5'(5 + $urandom_range(10));
        cfg(4'h3, p, p[3:0]);
        check_all("self_no_vbus");
        @(posedge clk_sys);
        vbus_req <= 1'b1;
        suspend_req <= 1'b1;
        check_all("self_vbus_suspend");
        cfg(4'h3, p, (p == 5'hf) ? 4'h5 : p[3:0] + 4'h1);
        check_all("self_mismatch");
        cfg(4'h3, p, p[3:0]);
        @(posedge clk_sys);
        vbus_req <= 1'b0;
        check_all("self_vbus_lost");
        cfg(4'h9, 5'h10, 4'h2);
        d = 32'(8 + $urandom_range(7));
        m_dsel <= d[3:0];
        m_wsel <= d[3:0] - 4'h8;
        reg_wr(UADC_OFS_DETACH_SEL, d);
        reg_wr(UADC_OFS_WAKE_SEL, d - 32'h8);
        check_all("pins_moved");
        @(posedge clk_sys);
        m_det <= 1'b1;
        check_all("detach_moved");
        @(posedge clk_sys);
        m_det <= 1'b0;
        check_all("reattach_moved");
        tally_and_finish();
    end

    initial begin
        #(40 * 20000);
        mismatches++;
        tally_and_finish();
    end
endmodule
